/* File: hw/afe_consts.svh */
// Purpose: Constants for the converter front-end configuration block.
// Assumes: Registers are reached over the special function register port of the CPU core.
// Notes: Offsets are special function register addresses.
// Operation
// - An input selection value of all ones disconnects every external input and the common input and routes the converter to the temperature diodes.
// - While control bit 6 is set, the two burnout current sources on the selected pair are enabled.
// - Control bit 3 enables the input buffer when one and disables it when zero.
// - Control bits 2 to 0 select gains 1 to 128 in powers of two, with gain 1 by default.
// - An 8-bit offset trim register at address e6 gives a sign in its top bit and a seven-bit magnitude below it.
// - A byte write to control register zero replaces every bit of that register.
// - Input selection bits 7 to 4 pick the positive channel and bits 3 to 0 the negative one, resetting to 01.
// - The conversion interrupt is raised when a requested calibration completes.
`ifndef AFE_CONSTS_SVH
`define AFE_CONSTS_SVH
`define AFE_ADDR_INPUT_SEL 8'hd7
`define AFE_ADDR_CTRL_ZERO 8'hdc
`define AFE_ADDR_OFFSET_TRIM 8'he6
`define AFE_ADDR_CLK_DIV 8'hf6
`define AFE_RST_INPUT_SEL 8'h01
`define AFE_RST_CTRL_ZERO 8'h00
`define AFE_RST_OFFSET_TRIM 8'h00
`define AFE_RST_CLK_DIV 8'h00
`define AFE_TEMP_SEL 8'hff
`define AFE_BIT_BURNOUT 6
`define AFE_BIT_BUFFER 3
`define AFE_GAIN_HI 2
`define AFE_GAIN_LO 0
`define AFE_POS_HI 7
`define AFE_POS_LO 4
`define AFE_NEG_HI 3
`define AFE_NEG_LO 0
`define AFE_TRIM_SIGN 7
`define AFE_TRIM_MAG_HI 6
`define AFE_COM_CODE 4'h8
`define AFE_NUM_INPUTS 8
`define AFE_RDATA_IDLE 8'h00
`define AFE_GAIN_UNIT 8'h01
`define AFE_TRIM_MAG_LO 0
`endif

/* File: hw/afe_pkg.sv */
// Purpose: Types for the converter front-end configuration block.
// Assumes: Used with afe_consts.svh.
// Notes: Calibration tracker states are one-hot.
`default_nettype none
package afe_pkg;
	typedef enum logic [1:0] {
		AFE_CAL_IDLE = 2'b01,
		AFE_CAL_BUSY = 2'b10
	} afe_cal_state_e;
	typedef logic [7:0] afe_byte_t;
endpackage
`default_nettype wire

/* File: hw/afe_channel_decode.sv */
// Purpose: Turns a four-bit channel code into one-hot input switch enables.
// Assumes: Codes 0 to 7 are external inputs, 8 is the common input.
// Notes: Temperature routing overrides every switch.
`include "afe_consts.svh"
`default_nettype none
module afe_channel_decode (
	// Selection
	input wire logic [3:0] code,
	input wire logic temp_route,
	// Switch enables
	output logic [`AFE_NUM_INPUTS-1:0] ain_on,
	output logic com_on
);
	// One switch per external input, all opened for the temperature diodes.
	genvar i;
	generate
		for (i = 0; i < `AFE_NUM_INPUTS; i = i + 1) begin : g_sw
			assign ain_on[i] = !temp_route && (code == 4'(i));
		end
	endgenerate
	assign com_on = !temp_route && (code == `AFE_COM_CODE);
endmodule
`default_nettype wire

/* File: hw/afe_front_end_config.sv */
// Purpose: Special function registers and analog control outputs of the converter front end.
// Assumes: Single-cycle register write and read strobes from the CPU core.
// Notes: Read data is registered and valid the cycle after the read strobe.
// Notes: Every analog control output is a plain decode of a register, so it changes one cycle after the write.
// Notes: A write and a read to the same register in one cycle return the old value, since the read
// multiplexer looks at the register before the write edge updates it.
// Notes: Unmapped addresses are ignored on write and read back as zero; the hit flag tells the core
// whether an address belongs to this block.
// Notes: The calibration tracker only follows the modulator's start and done pulses; the sequencing
// itself lives elsewhere.
// Notes: The conversion flag is sticky: a completion in the same cycle as a clear leaves it set, so a
// finished calibration is never lost to a late clear.
// Notes: Hardware does not stop a trim write during calibration; software watches the busy level
// and writes the trim only once calibration is over, or the calibration cancels the trim.
`include "afe_consts.svh"
`default_nettype none
module afe_front_end_config (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// Calibration handshake with the modulator
	input wire logic cal_start,
	input wire logic cal_done,
	input wire logic conv_ready_clr,
	output logic conversion_ready_flag,
	output logic cal_busy,
	// Analog controls
	output logic [`AFE_NUM_INPUTS-1:0] pos_ain_on,
	output logic pos_com_on,
	output logic [`AFE_NUM_INPUTS-1:0] neg_ain_on,
	output logic neg_com_on,
	output logic temp_diodes_on,
	output logic burnout_detect_enable,
	output logic buffer_enable,
	output logic [2:0] gain_select,
	output logic [7:0] pga_gain,
	output logic offset_sign,
	output logic [6:0] offset_mag,
	output logic [7:0] analog_clock_divider
);
	afe_pkg::afe_byte_t input_selection_reg;
	afe_pkg::afe_byte_t converter_control_zero_reg;
	afe_pkg::afe_byte_t offset_trim_reg;
	afe_pkg::afe_byte_t analog_clock_divider_reg;
	afe_pkg::afe_byte_t sfr_rdata_reg;
	afe_pkg::afe_byte_t sfr_rdata_next;
	afe_pkg::afe_cal_state_e cal_state_reg;
	afe_pkg::afe_cal_state_e cal_state_next;
	logic conv_ready_reg;
	logic conv_ready_next;

	// Register images gated by their select, merged into the read value below.
	wire [7:0] rd_input;
	wire [7:0] rd_ctrl;
	wire [7:0] rd_trim;
	wire [7:0] rd_div;

	// Tracker events that the current state accepts.
	wire cal_take_start;
	wire cal_take_done;

	// Address decode of the four registers.
	wire sel_input = (sfr_addr == `AFE_ADDR_INPUT_SEL);
	wire sel_ctrl = (sfr_addr == `AFE_ADDR_CTRL_ZERO);
	wire sel_trim = (sfr_addr == `AFE_ADDR_OFFSET_TRIM);
	wire sel_div = (sfr_addr == `AFE_ADDR_CLK_DIV);
	wire any_sel = sel_input | sel_ctrl | sel_trim | sel_div;
	assign sfr_hit = any_sel;

	// Register file; a write replaces the whole byte.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			input_selection_reg <= `AFE_RST_INPUT_SEL;
			converter_control_zero_reg <= `AFE_RST_CTRL_ZERO;
			offset_trim_reg <= `AFE_RST_OFFSET_TRIM;
			analog_clock_divider_reg <= `AFE_RST_CLK_DIV;
		end else if (sfr_wr) begin
			if (sel_input) input_selection_reg <= sfr_wdata;
			if (sel_ctrl) converter_control_zero_reg <= sfr_wdata;
			if (sel_trim) offset_trim_reg <= sfr_wdata;
			if (sel_div) analog_clock_divider_reg <= sfr_wdata;
		end
	end

	// Each register drives the read value only while its address is selected.
	assign rd_input = sel_input ? input_selection_reg : `AFE_RDATA_IDLE;
	assign rd_ctrl = sel_ctrl ? converter_control_zero_reg : `AFE_RDATA_IDLE;
	assign rd_trim = sel_trim ? offset_trim_reg : `AFE_RDATA_IDLE;
	assign rd_div = sel_div ? analog_clock_divider_reg : `AFE_RDATA_IDLE;

	// Read multiplexer; the selects are exclusive, so unmapped addresses read as zero.
	assign sfr_rdata_next = rd_input | rd_ctrl | rd_trim | rd_div;

	// Registered read data.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata_reg <= `AFE_RDATA_IDLE;
		end else if (sfr_rd) begin
			sfr_rdata_reg <= sfr_rdata_next;
		end
	end
	assign sfr_rdata = sfr_rdata_reg;

	// Channel routing; all ones selects the temperature diodes.
	assign temp_diodes_on = (input_selection_reg == `AFE_TEMP_SEL);

	afe_channel_decode u_pos (
		.code(input_selection_reg[`AFE_POS_HI:`AFE_POS_LO]),
		.temp_route(temp_diodes_on),
		.ain_on(pos_ain_on),
		.com_on(pos_com_on)
	);

	afe_channel_decode u_neg (
		.code(input_selection_reg[`AFE_NEG_HI:`AFE_NEG_LO]),
		.temp_route(temp_diodes_on),
		.ain_on(neg_ain_on),
		.com_on(neg_com_on)
	);

	// Analog control fields of control register zero.
	assign burnout_detect_enable = converter_control_zero_reg[`AFE_BIT_BURNOUT];
	assign buffer_enable = converter_control_zero_reg[`AFE_BIT_BUFFER];
	assign gain_select = converter_control_zero_reg[`AFE_GAIN_HI:`AFE_GAIN_LO];
	assign pga_gain = `AFE_GAIN_UNIT << gain_select;

	// Offset trim split into sign and magnitude.
	assign offset_sign = offset_trim_reg[`AFE_TRIM_SIGN];
	assign offset_mag = offset_trim_reg[`AFE_TRIM_MAG_HI:`AFE_TRIM_MAG_LO];
	assign analog_clock_divider = analog_clock_divider_reg;

	// Start is taken only while idle and done only while busy; stray pulses are ignored.
	assign cal_take_start = (cal_state_reg == afe_pkg::AFE_CAL_IDLE) && cal_start;
	assign cal_take_done = (cal_state_reg == afe_pkg::AFE_CAL_BUSY) && cal_done;

	// Calibration tracker and conversion flag; a set beats a clear.
	always_comb begin
		cal_state_next = cal_state_reg;
		conv_ready_next = conv_ready_reg;
		if (conv_ready_clr) conv_ready_next = 1'b0;
		case (cal_state_reg)
			afe_pkg::AFE_CAL_IDLE: begin
				if (cal_take_start) cal_state_next = afe_pkg::AFE_CAL_BUSY;
			end
			afe_pkg::AFE_CAL_BUSY: begin
				if (cal_take_done) begin
					cal_state_next = afe_pkg::AFE_CAL_IDLE;
					conv_ready_next = 1'b1;
				end
			end
			default: cal_state_next = afe_pkg::AFE_CAL_IDLE;
		endcase
	end

	// State registers of the tracker.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_state_reg <= afe_pkg::AFE_CAL_IDLE;
			conv_ready_reg <= 1'b0;
		end else begin
			cal_state_reg <= cal_state_next;
			conv_ready_reg <= conv_ready_next;
		end
	end
	assign conversion_ready_flag = conv_ready_reg;
	assign cal_busy = (cal_state_reg == afe_pkg::AFE_CAL_BUSY);
endmodule
`default_nettype wire

/* File: tb/afe_fec_chk.sv */
// Purpose: Port assertions for the front-end configuration block.
// Assumes: One clock and an asynchronous active-low reset.
// Notes: Write effects are checked one cycle after the taking edge.
`default_nettype none
module afe_fec_chk (
	// Clock, reset and register port
	input wire logic ref_clk, rst_n, sfr_wr, sfr_rd,
	input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
	// Calibration and analog controls
	input wire logic cal_done, cal_busy, conversion_ready_flag, pos_com_on, neg_com_on, temp_diodes_on,
	input wire logic burnout_detect_enable, buffer_enable, offset_sign,
	input wire logic [7:0] pos_ain_on, neg_ain_on, pga_gain,
	input wire logic [2:0] gain_select,
	input wire logic [6:0] offset_mag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Write strobes decoded for the selection, control and trim registers.
	wire logic ws = sfr_wr && sfr_addr == 8'hd7;
	wire logic wc = sfr_wr && sfr_addr == 8'hdc;
	wire logic wt = sfr_wr && sfr_addr == 8'he6;
	property p_temp; ws && sfr_wdata == 8'hff |=> temp_diodes_on && {pos_ain_on, neg_ain_on, pos_com_on, neg_com_on} == 18'h0; endproperty
	a_temp: assert property (p_temp) else $error("temp routing");
	property p_bod; wc |=> burnout_detect_enable == $past(sfr_wdata[6]); endproperty
	a_bod: assert property (p_bod) else $error("burnout");
	property p_buf; wc |=> buffer_enable == $past(sfr_wdata[3]); endproperty
	a_buf: assert property (p_buf) else $error("buffer");
	property p_gain; wc |=> gain_select == $past(sfr_wdata[2:0]) && pga_gain == 8'h1 << gain_select; endproperty
	a_gain: assert property (p_gain) else $error("gain");
	property p_trim; wt |=> offset_sign == $past(sfr_wdata[7]) && offset_mag == $past(sfr_wdata[6:0]); endproperty
	a_trim: assert property (p_trim) else $error("trim");
	property p_sel; ws && !sfr_wdata[7] && !sfr_wdata[3] |=> pos_ain_on == 8'h1 << $past(sfr_wdata[6:4])
		&& neg_ain_on == 8'h1 << $past(sfr_wdata[2:0]); endproperty
	a_sel: assert property (p_sel) else $error("selection");
	property p_rd; sfr_rd && sfr_addr == 8'he6 |=> sfr_rdata == {$past(offset_sign), $past(offset_mag)}; endproperty
	a_rd: assert property (p_rd) else $error("readback");
	property p_irq; cal_busy && cal_done |=> conversion_ready_flag && !cal_busy; endproperty
	a_irq: assert property (p_irq) else $error("cal flag");
endmodule
bind afe_front_end_config afe_fec_chk i_chk (.*);
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the front-end configuration block.
// Assumes: Inputs change on the falling clock edge.
// Notes: Each row holds control write data beside the expected gain.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'h0, rst_n = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0;
	logic cal_start = 1'h0, cal_done = 1'h0, conv_ready_clr = 1'h0;
	logic [7:0] sfr_addr = 8'h0, sfr_wdata = 8'h0, sfr_rdata, pos_ain_on, neg_ain_on, pga_gain, analog_clock_divider;
	logic [6:0] offset_mag;
	logic [2:0] gain_select;
	logic sfr_hit, conversion_ready_flag, cal_busy, pos_com_on, neg_com_on;
	logic temp_diodes_on, burnout_detect_enable, buffer_enable, offset_sign;
	int fails = 0, compares = 0;
	logic [15:0] rows [8] = '{16'h0001, 16'h4102, 16'h0a04, 16'h4b08, 16'hb410, 16'h4d20, 16'h0e40, 16'h4780};
	afe_front_end_config i_dut (.*);
	// Free-running clock.
	always #25 ref_clk = ~ref_clk;
	// Compares one value and counts a mismatch.
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// One-cycle write or read strobe.
	task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
		sfr_wr = w;
		sfr_rd = !w;
		sfr_addr = a;
		sfr_wdata = d;
		@(negedge ref_clk);
		sfr_wr = 1'h0;
		sfr_rd = 1'h0;
		@(negedge ref_clk);
	endtask
	// One-cycle pulse on a calibration input.
	task automatic pulse(ref logic p);
		p = 1'h1;
		@(negedge ref_clk);
		p = 1'h0;
	endtask
	// Prints the counts and the verdict.
	task automatic tally_and_finish;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence: reset, table of control writes, then awkward cases.
	initial begin
		repeat (8) @(negedge ref_clk);
		rst_n = 1'h1;
		chk("pos", pos_ain_on, 8'h01);
		chk("neg", neg_ain_on, 8'h02);
		chk("gain", pga_gain, 8'h01);
		$display("reset test done");
		foreach (rows[i]) begin
			acc(1'h1, 8'hdc, rows[i][15:8]);
			chk("gain", pga_gain, rows[i][7:0]);
			chk("gsel", {5'h0, gain_select}, {5'h0, rows[i][10:8]});
			chk("bod", {7'h0, burnout_detect_enable}, {7'h0, rows[i][14]});
			chk("buf", {7'h0, buffer_enable}, {7'h0, rows[i][11]});
			acc(1'h0, 8'hdc, 8'h0);
			chk("ctrl", sfr_rdata, rows[i][15:8]);
		end
		$display("table test done");
		acc(1'h1, 8'hd7, 8'hff);
		chk("temp", {temp_diodes_on, pos_com_on, neg_com_on, 5'h0}, 8'h80);
		chk("sw", pos_ain_on | neg_ain_on, 8'h0);
		acc(1'h1, 8'hd7, 8'h86);
		chk("com", {pos_com_on, neg_com_on, 6'h0}, 8'h80);
		chk("neg", neg_ain_on, 8'h40);
		pulse(cal_done);
		chk("flag", {7'h0, conversion_ready_flag}, 8'h0);
		pulse(cal_start);
		chk("busy", {7'h0, cal_busy}, 8'h1);
		pulse(cal_done);
		chk("flag", {7'h0, conversion_ready_flag}, 8'h1);
		chk("busy", {7'h0, cal_busy}, 8'h0);
		pulse(conv_ready_clr);
		chk("flag", {7'h0, conversion_ready_flag}, 8'h0);
		pulse(cal_start);
		cal_done = 1'h1;
		conv_ready_clr = 1'h1;
		@(negedge ref_clk);
		cal_done = 1'h0;
		conv_ready_clr = 1'h0;
		chk("set wins", {7'h0, conversion_ready_flag}, 8'h1);
		pulse(conv_ready_clr);
		acc(1'h1, 8'he6, 8'h90);
		chk("trim", {offset_sign, offset_mag}, 8'h90);
		acc(1'h0, 8'he6, 8'h0);
		chk("trim rd", sfr_rdata, 8'h90);
		acc(1'h1, 8'hf6, 8'h09);
		chk("div", analog_clock_divider, 8'h09);
		acc(1'h0, 8'h55, 8'h0);
		chk("unmapped", {sfr_hit, sfr_rdata[6:0]}, 8'h0);
		$display("hand tests done");
		tally_and_finish;
	end
	// Watchdog well beyond the expected run of about 60 cycles.
	initial begin
		#20000;
		fails++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
